// ===== logic/sph_top.sv
// set point object handler with axi4-lite configuration and status registers
`timescale 1ns/100ps
`default_nettype none
module sph_top (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [7:0]             awaddr,
   input  wire logic [2:0]             awprot,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [7:0]             araddr,
   input  wire logic [2:0]             arprot,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic signed [15:0]     temp_sense,
   input  wire logic signed [15:0]     outdoor_temp,
   input  wire logic signed [15:0]     knob_base,
   input  wire logic signed [15:0]     knob_offset,
   input  wire logic                   comfort_heat,
   input  wire logic                   rx_valid,
   input  wire sph_pkg::sph_obj_t      rx_msg,
   output logic                        tx_valid,
   output sph_pkg::sph_obj_t           tx_msg,
   output logic [7:0]                  led_level,
   output logic signed [15:0]          cur_setpoint
);
   logic        awready_q, awready_d, arready_q, arready_d;
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] cfg_q, cfg_d, splim_q, splim_d, oflim_q, oflim_d, comp_q, comp_d;
   logic signed [15:0] base_q, base_d, offs_q, offs_d, corr_q, corr_d, cur_q, cur_d;
   logic [7:0]  led_q, led_d;
   logic        tx_valid_q, tx_valid_d;
   sph_pkg::sph_obj_t tx_msg_q, tx_msg_d;
   localparam int N_TXW = sph_pkg::N_TX;
   logic [N_TXW-1:0] fresh_q, fresh_d;
   logic signed [15:0] sent_q [4];
   logic signed [15:0] sent_d [4];

   sph_pkg::sph_knob_t knob;
   logic signed [15:0] sp_min, sp_max, of_min, of_max, c_thr, c_max;
   logic signed [15:0] base_knob_exp, base_rx_exp, offs_rx_exp, cur_exp, corr_calc;
   logic signed [16:0] out_excess;
   logic signed [15:0] tx_val [4];
   logic [3:0]         tx_en;
   logic               rx_base, rx_offs, rx_corr, rx_led;

   assign knob   = sph_pkg::sph_knob_t'(cfg_q[sph_pkg::CFG_KNOB_LSB +: 2]);
   assign sp_min = splim_q[15:0];
   assign sp_max = splim_q[31:16];
   assign of_min = oflim_q[15:0];
   assign of_max = oflim_q[31:16];
   assign c_thr  = comp_q[15:0];
   assign c_max  = comp_q[31:16];
   assign rx_base = rx_valid && rx_msg.num == sph_pkg::OBJ_BASE;
   assign rx_offs = rx_valid && rx_msg.num == sph_pkg::OBJ_OFFS;
   assign rx_corr = rx_valid && rx_msg.num == sph_pkg::OBJ_CORR;
   assign rx_led  = rx_valid && rx_msg.num == sph_pkg::OBJ_LED;

   assign base_knob_exp = sph_pkg::sph_clamp(17'(knob_base), sp_min, sp_max);
   assign base_rx_exp   = sph_pkg::sph_clamp(17'(rx_msg.value), sp_min, sp_max);
   assign offs_rx_exp   = sph_pkg::sph_clamp(17'(rx_msg.value), of_min, of_max);
   // always base + offset, so repeated offsets never pile up
   assign cur_exp       = sph_pkg::sph_clamp(17'(base_q) + 17'(offs_q), sp_min, sp_max);  // [R10]
   assign out_excess    = 17'(outdoor_temp) - 17'(c_thr);
   assign corr_calc     = (out_excess <= 17'sd0) ? 16'sh0000
                          : sph_pkg::sph_clamp(out_excess, 16'sh0000, c_max);

   // ---------------- bus objects ----------------
   always_comb begin
      base_d = base_q;
      offs_d = offs_q;
      corr_d = corr_q;
      led_d  = led_q;
      if (knob == sph_pkg::KNOB_BASE) begin
         base_d = base_knob_exp;  // [R3]
      end else if (rx_base) begin
         base_d = base_rx_exp;  // [R4] [R5]
      end
      if (knob == sph_pkg::KNOB_OFFSET) begin
         offs_d = knob_offset;  // [R11]
      end else if (rx_offs) begin
         if (rx_msg.value == 16'sh0000) begin
            offs_d = 16'sh0000;  // [R9]
         end else begin
            offs_d = offs_rx_exp;  // [R6] [R8]
         end
      end
      if (cfg_q[sph_pkg::CFG_COMP_INT]) begin
         corr_d = corr_calc;  // [R13]
      end else if (rx_corr) begin
         corr_d = rx_msg.value;  // [R12]
      end
      if (rx_led) begin
         // switch format: bit 0 of the value alone selects full brightness or off
         led_d = cfg_q[sph_pkg::CFG_LED_PCT] ? rx_msg.value[7:0] : {8{rx_msg.value[0]}};  // [R2]
      end
      cur_d = comfort_heat ? cur_exp : base_q;  // [R7]
   end

   // ---------------- transmit scheduler ----------------
   assign tx_val[0] = temp_sense;  // [R1]
   assign tx_val[1] = base_q;
   assign tx_val[2] = offs_q;
   assign tx_val[3] = cfg_q[sph_pkg::CFG_COMP_ABS] ? 16'(base_q + corr_q) : corr_q;  // [R14] [R15]
   assign tx_en     = {cfg_q[sph_pkg::CFG_COMP_INT], knob == sph_pkg::KNOB_OFFSET,
                       knob == sph_pkg::KNOB_BASE, 1'b1};  // [R1] [R3] [R11] [R13]

   always_comb begin
      logic [31:0] nums;
      nums       = {sph_pkg::OBJ_CORR, sph_pkg::OBJ_OFFS, sph_pkg::OBJ_BASE, sph_pkg::OBJ_TEMP};
      tx_valid_d = 1'b0;
      tx_msg_d   = tx_msg_q;
      fresh_d    = fresh_q;
      sent_d     = sent_q;
      // lowest object number wins; one object per cycle
      for (int i = N_TXW - 1; i >= 0; i--) begin
         if (tx_en[i] && (fresh_q[i] || tx_val[i] != sent_q[i])) begin
            tx_valid_d = 1'b1;
            tx_msg_d   = '{num: nums[i*8 +: 8], value: tx_val[i]};
         end
      end
      for (int i = 0; i < N_TXW; i++) begin
         if (tx_valid_d && tx_msg_d.num == nums[i*8 +: 8]) begin
            sent_d[i]  = tx_val[i];
            fresh_d[i] = 1'b0;
         end
      end
   end

   // ---------------- axi4-lite slave ----------------
   always_comb begin
      logic [31:0] m;
      m         = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      awready_d = 1'b0;
      arready_d = 1'b0;
      bvalid_d  = bvalid_q && !bready;
      rvalid_d  = rvalid_q && !rready;
      bresp_d   = bresp_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      cfg_d     = cfg_q;
      splim_d   = splim_q;
      oflim_d   = oflim_q;
      comp_d    = comp_q;
      // address and data are taken together, one write at a time
      if (awvalid && wvalid && !awready_q && !bvalid_q) begin
         awready_d = 1'b1;
      end
      if (awready_q) begin
         bvalid_d = 1'b1;
         bresp_d  = sph_pkg::RESP_OKAY;
         if (awaddr == sph_pkg::ADDR_CFG) begin
            cfg_d = (cfg_q & ~m) | (wdata & m);
         end else if (awaddr == sph_pkg::ADDR_SP_LIM) begin
            splim_d = (splim_q & ~m) | (wdata & m);
         end else if (awaddr == sph_pkg::ADDR_OF_LIM) begin
            oflim_d = (oflim_q & ~m) | (wdata & m);
         end else if (awaddr == sph_pkg::ADDR_COMP) begin
            comp_d = (comp_q & ~m) | (wdata & m);
         end else if (awaddr != sph_pkg::ADDR_ST_SP && awaddr != sph_pkg::ADDR_ST_CUR
                      && awaddr != sph_pkg::ADDR_ST_MEA) begin
            bresp_d = sph_pkg::RESP_SLV;
         end
      end
      if (arvalid && !arready_q && !rvalid_q) begin
         arready_d = 1'b1;
      end
      if (arready_q) begin
         rvalid_d = 1'b1;
         rresp_d  = sph_pkg::RESP_OKAY;
         if (araddr == sph_pkg::ADDR_CFG) begin
            rdata_d = {27'h000_0000, cfg_q[4:0]};
         end else if (araddr == sph_pkg::ADDR_SP_LIM) begin
            rdata_d = splim_q;
         end else if (araddr == sph_pkg::ADDR_OF_LIM) begin
            rdata_d = oflim_q;
         end else if (araddr == sph_pkg::ADDR_COMP) begin
            rdata_d = comp_q;
         end else if (araddr == sph_pkg::ADDR_ST_SP) begin
            rdata_d = {offs_q, base_q};
         end else if (araddr == sph_pkg::ADDR_ST_CUR) begin
            rdata_d = {corr_q, cur_q};
         end else if (araddr == sph_pkg::ADDR_ST_MEA) begin
            rdata_d = {led_q, 8'h00, temp_sense};
         end else begin
            rdata_d = 32'h0000_0000;
            rresp_d = sph_pkg::RESP_SLV;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q  <= 1'b0;
         arready_q  <= 1'b0;
         bvalid_q   <= 1'b0;
         rvalid_q   <= 1'b0;
         bresp_q    <= sph_pkg::RESP_OKAY;
         rresp_q    <= sph_pkg::RESP_OKAY;
         rdata_q    <= 32'h0000_0000;
         cfg_q      <= sph_pkg::RST_CFG;
         splim_q    <= sph_pkg::RST_SP_LIM;
         oflim_q    <= sph_pkg::RST_OF_LIM;
         comp_q     <= sph_pkg::RST_COMP;
         base_q     <= sph_pkg::RST_BASE;  // [R4]
         offs_q     <= 16'sh0000;
         corr_q     <= 16'sh0000;
         cur_q      <= sph_pkg::RST_BASE;
         led_q      <= 8'hff;
         tx_valid_q <= 1'b0;
         tx_msg_q   <= '0;
         fresh_q    <= '1;
         for (int i = 0; i < N_TXW; i++) begin
            sent_q[i] <= 16'sh0000;
         end
      end else begin
         awready_q  <= awready_d;
         arready_q  <= arready_d;
         bvalid_q   <= bvalid_d;
         rvalid_q   <= rvalid_d;
         bresp_q    <= bresp_d;
         rresp_q    <= rresp_d;
         rdata_q    <= rdata_d;
         cfg_q      <= cfg_d;
         splim_q    <= splim_d;
         oflim_q    <= oflim_d;
         comp_q     <= comp_d;
         base_q     <= base_d;
         offs_q     <= offs_d;
         corr_q     <= corr_d;
         cur_q      <= cur_d;
         led_q      <= led_d;
         tx_valid_q <= tx_valid_d;
         tx_msg_q   <= tx_msg_d;
         fresh_q    <= fresh_d;
         sent_q     <= sent_d;
      end
   end

   assign awready      = awready_q;
   assign wready       = awready_q;
   assign bvalid       = bvalid_q;
   assign bresp        = bresp_q;
   assign arready      = arready_q;
   assign rvalid       = rvalid_q;
   assign rresp        = rresp_q;
   assign rdata        = rdata_q;
   assign tx_valid     = tx_valid_q;
   assign tx_msg       = tx_msg_q;
   assign led_level    = led_q;
   assign cur_setpoint = cur_q;

   // ---------------- assertions ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_temp_sent: assert property (tx_valid_q && tx_msg_q.num == sph_pkg::OBJ_TEMP  // [R1]
      |-> tx_msg_q.value == $past(temp_sense)) else $error("temperature object value wrong");
   a_led_pct: assert property (rx_led && cfg_q[sph_pkg::CFG_LED_PCT]  // [R2]
      |=> led_q == $past(rx_msg.value[7:0])) else $error("brightness not taken");
   a_base_knob: assert property (knob == sph_pkg::KNOB_BASE  // [R3]
      |=> base_q == $past(base_knob_exp)) else $error("knob base not followed");
   a_base_init: assert property (disable iff (1'b0) !aresetn  // [R4]
      |=> base_q == sph_pkg::RST_BASE) else $error("base not loaded at start");
   a_base_rx: assert property (rx_base && knob != sph_pkg::KNOB_BASE  // [R5]
      |=> base_q == $past(base_rx_exp) && base_q >= $past(sp_min)) else $error("received base wrong");
   a_offs_rx: assert property (rx_offs && knob != sph_pkg::KNOB_OFFSET && rx_msg.value != 16'sh0000  // [R8]
      |=> offs_q == $past(offs_rx_exp)) else $error("received offset not saturated");
   a_offs_zero: assert property (rx_offs && knob != sph_pkg::KNOB_OFFSET && rx_msg.value == 16'sh0000  // [R9]
      |=> offs_q == 16'sh0000) else $error("zero offset did not clear");
   a_cur_sum: assert property (comfort_heat ##1 comfort_heat && $stable(base_q) && $stable(offs_q)  // [R7]
      |=> cur_q == $past(cur_exp)) else $error("current set point wrong");
   a_offs_knob: assert property (knob == sph_pkg::KNOB_OFFSET  // [R11]
      |=> offs_q == $past(knob_offset)) else $error("knob offset not followed");
   a_corr_rx: assert property (rx_corr && !cfg_q[sph_pkg::CFG_COMP_INT]  // [R12]
      |=> corr_q == $past(rx_msg.value)) else $error("correction not received");
   a_corr_abs: assert property (tx_valid_q && tx_msg_q.num == sph_pkg::OBJ_CORR  // [R14]
      && $past(cfg_q[sph_pkg::CFG_COMP_ABS])
      |-> tx_msg_q.value == 16'($past(base_q) + $past(corr_q))) else $error("absolute correction wrong");
   a_corr_rel: assert property (tx_valid_q && tx_msg_q.num == sph_pkg::OBJ_CORR  // [R15]
      && !$past(cfg_q[sph_pkg::CFG_COMP_ABS]) |-> tx_msg_q.value == $past(corr_q))
      else $error("relative correction wrong");
   c_base_rx: cover property (rx_base ##1 tx_valid_q);
   c_offs_sat: cover property (rx_offs && rx_msg.value > of_max);
   c_corr_tx: cover property (tx_valid_q && tx_msg_q.num == sph_pkg::OBJ_CORR);
endmodule : sph_top
`default_nettype wire

// ===== logic/sph_pkg.sv
// package for the set point object handler: constants, types, clamp helper
// How it works
// [R1] send internally measured room temperature
// [R2] brightness object: percent byte sets directly
// [R3] knob on base: send knob base
// [R4] else receive base, start from initial
// [R5] received base clamped to min/max
// [R6] knob base/blocked: receive offset
// [R7] comfort heating: current = base + offset
// [R8] offset beyond range saturates, never rejected
// [R9] received zero offset clears offset
// [R10] offset relative to base, never accumulates
// [R11] knob on offset: send knob offset
// [R12] receive-only: take correction from bus
// [R13] internal: compute correction, send per format
// [R14] absolute: send base plus correction
// [R15] relative: send correction alone in kelvin
`default_nettype none
package sph_pkg;
   typedef enum logic [1:0] {KNOB_BASE, KNOB_OFFSET, KNOB_BLOCKED} sph_knob_t;
   typedef struct packed {
      logic [7:0]         num;
      logic signed [15:0] value;
   } sph_obj_t;
   // bus object numbers
   localparam logic [7:0]  OBJ_TEMP = 8'h01;
   localparam logic [7:0]  OBJ_LED  = 8'h02;
   localparam logic [7:0]  OBJ_BASE = 8'h0a;
   localparam logic [7:0]  OBJ_OFFS = 8'h0b;
   localparam logic [7:0]  OBJ_CORR = 8'h0c;
   localparam int          N_TX     = 4;
   // register byte offsets
   localparam logic [7:0]  ADDR_CFG    = 8'h00;
   localparam logic [7:0]  ADDR_SP_LIM = 8'h04;
   localparam logic [7:0]  ADDR_OF_LIM = 8'h08;
   localparam logic [7:0]  ADDR_COMP   = 8'h0c;
   localparam logic [7:0]  ADDR_ST_SP  = 8'h10;
   localparam logic [7:0]  ADDR_ST_CUR = 8'h14;
   localparam logic [7:0]  ADDR_ST_MEA = 8'h18;
   // cfg field positions
   localparam int          CFG_KNOB_LSB = 0;
   localparam int          CFG_LED_PCT  = 2;
   localparam int          CFG_COMP_INT = 3;
   localparam int          CFG_COMP_ABS = 4;
   // reset values, temperatures in 0.01 degree steps
   localparam logic [31:0] RST_CFG    = 32'h0000_0000;
   localparam logic [31:0] RST_SP_LIM = 32'h0bb8_01f4;
   localparam logic [31:0] RST_OF_LIM = 32'h012c_fed4;
   localparam logic [31:0] RST_COMP   = 32'h01f4_09c4;
   localparam logic [15:0] RST_BASE   = 16'h0834;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   function automatic logic signed [15:0] sph_clamp(input logic signed [16:0] v,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
      if (v < 17'(lo)) begin
         return lo;
      end else if (v > 17'(hi)) begin
         return hi;
      end else begin
         return v[15:0];
      end
   endfunction : sph_clamp
endpackage : sph_pkg
`default_nettype wire

// ===== tb/sph_bus_node.sv
// far-side bus node model: sends objects to the handler, records what it sends
`timescale 1ns/100ps
`default_nettype none
module sph_bus_node (
   input  wire logic              aclk,
   output logic                   rx_valid,
   output sph_pkg::sph_obj_t      rx_msg,
   input  wire logic              tx_valid,
   input  wire sph_pkg::sph_obj_t tx_msg
);
   logic signed [15:0] last_val [0:255];
   initial begin
      rx_valid = 1'b0;
      rx_msg   = '0;
   end
   // one object per pulse; lines scrambled once released so stale data never looks valid
   task automatic send(input logic [7:0] num, input logic signed [15:0] v);
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_msg   <= {num, v};
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_msg   <= ~{num, v};
   endtask : send
   always @(posedge aclk) begin
      if (tx_valid) begin
         last_val[tx_msg.num] <= tx_msg.value;
      end
   end
endmodule : sph_bus_node
`default_nettype wire

// ===== tb/setpoint_object_handler_tb.sv
// self-checking bench for the set point object handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module setpoint_object_handler_tb;
   logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, comfort_heat;
   logic               awready, wready, bvalid, arready, rvalid, rx_valid, tx_valid;
   logic [7:0]         awaddr, araddr, led_level;
   logic [31:0]        wdata, rdata;
   logic [1:0]         bresp, rresp;
   logic signed [15:0] temp_sense, outdoor_temp, knob_base, knob_offset, cur_setpoint;
   sph_pkg::sph_obj_t  rx_msg, tx_msg;
   int                 n_errors, checks_done, i;
   logic [31:0]        rst_tab [4];

   sph_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .temp_sense(temp_sense), .outdoor_temp(outdoor_temp), .knob_base(knob_base),
      .knob_offset(knob_offset), .comfort_heat(comfort_heat), .rx_valid(rx_valid), .rx_msg(rx_msg),
      .tx_valid(tx_valid), .tx_msg(tx_msg), .led_level(led_level), .cur_setpoint(cur_setpoint));
   sph_bus_node far (.aclk(aclk), .rx_valid(rx_valid), .rx_msg(rx_msg), .tx_valid(tx_valid),
      .tx_msg(tx_msg));

   always #12.5 aclk = ~aclk;

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      // ready on both channels comes from one flop, so both drop together
      do @(posedge aclk); while (awready !== 1'b1);
      `CHK("wready", 1'b1, wready);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK("bresp", er, bresp);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK(nm, e, rdata);
      `CHK("rresp", er, rresp);
   endtask : rd

   task automatic see_tx(input logic [7:0] num, input logic signed [15:0] e);
      int n;
      for (n = 0; n < 20 && far.last_val[num] !== e; n++) begin
         @(posedge aclk);
      end
      `CHK("tx object", e, far.last_val[num]);
   endtask : see_tx

   task automatic cur_is(input logic signed [15:0] e);
      repeat (2) @(posedge aclk);
      `CHK("cur_setpoint", e, cur_setpoint);
   endtask : cur_is

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (6000) @(posedge aclk);
      n_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize();
   end

   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, comfort_heat} = '0;
      {awaddr, araddr, wdata} = '0;
      temp_sense   = 16'h0898;
      outdoor_temp = 16'h03e8;
      knob_base    = 16'h0898;
      knob_offset  = 16'h0000;
      rst_tab = '{sph_pkg::RST_CFG, sph_pkg::RST_SP_LIM, sph_pkg::RST_OF_LIM, sph_pkg::RST_COMP};
      repeat (6) @(posedge aclk);
      `CHK("cur_setpoint", 16'h0834, cur_setpoint);
      `CHK("led_level", 8'hff, led_level);
      aresetn <= 1'b1;
      for (i = 0; i < 4; i++) begin
         rd("reset value", 8'(4 * i), rst_tab[i], sph_pkg::RESP_OKAY);
      end
      rd("unmapped", 8'h1c, 32'h0000_0000, sph_pkg::RESP_SLV);
      wr(8'h20, 32'h0000_0001, sph_pkg::RESP_SLV);
      wr(sph_pkg::ADDR_ST_SP, 32'h1234_5678, sph_pkg::RESP_OKAY);
      rd("status sp", sph_pkg::ADDR_ST_SP, 32'h0000_0898, sph_pkg::RESP_OKAY);
      $display("test registers done");
      temp_sense <= 16'h0929;
      see_tx(sph_pkg::OBJ_TEMP, 16'h0929);
      knob_base <= 16'h09c4;
      see_tx(sph_pkg::OBJ_BASE, 16'h09c4);
      // knob owns the base, so a received base must not land
      far.send(sph_pkg::OBJ_BASE, 16'h07d0);
      rd("base knob", sph_pkg::ADDR_ST_SP, 32'h0000_09c4, sph_pkg::RESP_OKAY);
      $display("test transmit done");
      wr(sph_pkg::ADDR_CFG, 32'h0000_0002, sph_pkg::RESP_OKAY);
      far.send(sph_pkg::OBJ_BASE, 16'h0fa0);
      rd("base max", sph_pkg::ADDR_ST_SP, 32'h0000_0bb8, sph_pkg::RESP_OKAY);
      far.send(sph_pkg::OBJ_BASE, 16'h0064);
      rd("base min", sph_pkg::ADDR_ST_SP, 32'h0000_01f4, sph_pkg::RESP_OKAY);
      far.send(sph_pkg::OBJ_BASE, 16'h07d0);
      far.send(sph_pkg::OBJ_OFFS, 16'h01f4);
      // outside comfort heating the offset must not show
      cur_is(16'h07d0);
      comfort_heat <= 1'b1;
      rd("offset high", sph_pkg::ADDR_ST_SP, 32'h012c_07d0, sph_pkg::RESP_OKAY);
      cur_is(16'h08fc);
      far.send(sph_pkg::OBJ_OFFS, 16'hfc18);
      rd("offset low", sph_pkg::ADDR_ST_SP, 32'hfed4_07d0, sph_pkg::RESP_OKAY);
      cur_is(16'h06a4);
      far.send(sph_pkg::OBJ_OFFS, 16'h0064);
      far.send(sph_pkg::OBJ_OFFS, 16'h0064);
      cur_is(16'h0834);
      far.send(sph_pkg::OBJ_OFFS, 16'h0000);
      cur_is(16'h07d0);
      $display("test set point done");
      wr(sph_pkg::ADDR_CFG, 32'h0000_0001, sph_pkg::RESP_OKAY);
      knob_offset <= 16'h0096;
      see_tx(sph_pkg::OBJ_OFFS, 16'h0096);
      far.send(sph_pkg::OBJ_OFFS, 16'h0064);
      rd("offset knob", sph_pkg::ADDR_ST_SP, 32'h0096_07d0, sph_pkg::RESP_OKAY);
      wr(sph_pkg::ADDR_CFG, 32'h0000_0006, sph_pkg::RESP_OKAY);
      far.send(sph_pkg::OBJ_LED, 16'h0040);
      @(posedge aclk);
      `CHK("led percent", 8'h40, led_level);
      wr(sph_pkg::ADDR_CFG, 32'h0000_0002, sph_pkg::RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         far.send(sph_pkg::OBJ_LED, 16'(i));
         @(posedge aclk);
         `CHK("led switch", (i == 1) ? 8'hff : 8'h00, led_level);
      end
      $display("test knob and led done");
      far.send(sph_pkg::OBJ_OFFS, 16'h0000);
      far.send(sph_pkg::OBJ_CORR, 16'h0096);
      rd("corr rx", sph_pkg::ADDR_ST_CUR, 32'h0096_07d0, sph_pkg::RESP_OKAY);
      outdoor_temp <= 16'h0a8c;
      wr(sph_pkg::ADDR_CFG, 32'h0000_000a, sph_pkg::RESP_OKAY);
      see_tx(sph_pkg::OBJ_CORR, 16'h00c8);
      far.send(sph_pkg::OBJ_CORR, 16'h004d);
      rd("corr internal", sph_pkg::ADDR_ST_CUR, 32'h00c8_07d0, sph_pkg::RESP_OKAY);
      wr(sph_pkg::ADDR_CFG, 32'h0000_001a, sph_pkg::RESP_OKAY);
      see_tx(sph_pkg::OBJ_CORR, 16'h0898);
      $display("test correction done");
      summarize();
   end
endmodule : setpoint_object_handler_tb
`default_nettype wire
